// >>> src/drc_pkg.sv
package drc_pkg;
  // ==================================================
  // Configuration codes
  localparam logic [7:0] MULTI_KEY_INCHING = 8'h01;
  localparam logic [2:0] CMD_SRC_KEYPAD = 3'h0;
  localparam logic [2:0] CMD_SRC_TERM_ONE = 3'h1;
  localparam logic [5:0] FUNC_SPEED_UP = 6'h11;
  localparam logic [5:0] FUNC_SPEED_DOWN = 6'h12;
  localparam logic [5:0] FUNC_UD_CLEAR = 6'h14;
  localparam logic [5:0] FUNC_THREE_WIRE = 6'h0E;
  localparam logic UD_SAVE_ON = 1'b1;
  // ==================================================
  // Widths and timing
  localparam int FREQ_W = 16;
  localparam int NUM_TERM = 8;
  localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;
  localparam int CLK_HZ = 40000000;
  localparam int UD_STEP_TIME_US = 100;
  localparam int UD_STEP_CYCLES = (CLK_HZ / 1000000) * UD_STEP_TIME_US;
  localparam int MIN_INPUT_TIME_US = 1000;
  localparam int MIN_INPUT_CYCLES = (CLK_HZ / 1000000) * MIN_INPUT_TIME_US;
  // ==================================================
  // Types
  typedef enum logic [1:0] {
    DRC_DIR_STOP,
    DRC_DIR_FWD,
    DRC_DIR_REV
  } drc_dir_e;
  typedef enum logic [1:0] {
    DRC_RAMP_NORMAL,
    DRC_RAMP_INCH
  } drc_ramp_e;
endpackage : drc_pkg

// >>> src/drc_ud_if.sv
interface drc_ud_if;
  import drc_pkg::*;
  logic up;
  logic down;
  logic running;
  logic clear;
  logic save;
  logic [FREQ_W-1:0] maxFreq;
  logic [FREQ_W-1:0] freq;
  logic steady;
  modport ctrl (output up, output down, output running, output clear, output save,
    output maxFreq, input freq, input steady);
  modport core (input up, input down, input running, input clear, input save,
    input maxFreq, output freq, output steady);
endinterface : drc_ud_if

// >>> src/drc_updown.sv
module drc_updown #(
  parameter int STEP_CYCLES = drc_pkg::UD_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  drc_ud_if.core ud
);
  import drc_pkg::*;
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be positive");
  end
  logic [31:0] stepCnt;
  logic [FREQ_W-1:0] live;
  logic [FREQ_W-1:0] stored;
  logic wasRun;
  logic tick;
  assign tick = (stepCnt == 32'(STEP_CYCLES - 1));
  // ==================================================
  // Step timer
  always_ff @(posedge clk) begin
    if (srst || tick) begin
      stepCnt <= '0;
    end else begin
      stepCnt <= stepCnt + 32'h1;
    end
  end
  // ==================================================
  // Live up/down frequency
  always_ff @(posedge clk) begin
    if (srst) begin
      live <= FREQ_RESET;
    end else if (ud.running && !wasRun && ud.save) begin
      live <= (stored > ud.maxFreq) ? ud.maxFreq : stored;
    end else if (ud.running && !wasRun) begin
      live <= FREQ_RESET;
    end else if (ud.running && tick && ud.up && !ud.down) begin
      live <= (live >= ud.maxFreq) ? ud.maxFreq : live + 16'h0001;
    end else if (ud.running && tick && ud.down && !ud.up) begin
      live <= (live == 16'h0000) ? 16'h0000 : live - 16'h0001;
    end else if (live > ud.maxFreq) begin
      live <= ud.maxFreq;
    end
  end
  // ==================================================
  // Retained frequency
  always_ff @(posedge clk) begin
    if (srst) begin
      stored <= FREQ_RESET;
      wasRun <= 1'b0;
    end else begin
      wasRun <= ud.running;
      if (ud.clear && (!ud.running || ud.steady)) begin
        stored <= FREQ_RESET;
      end else if (ud.save && wasRun && !ud.running && ud.steady) begin
        stored <= live;
      end
    end
  end
  assign ud.freq = live;
  assign ud.steady = !(ud.up ^ ud.down);
  stored_hold_a: assert property (@(posedge clk) disable iff (srst)
    !ud.save |=> stored == $past(stored) || stored == FREQ_RESET)
    else $error("stored frequency changed without save");
  clamp_max_a: assert property (@(posedge clk) disable iff (srst)
    $past(live) <= $past(ud.maxFreq) && ud.maxFreq == $past(ud.maxFreq)
    |-> live <= ud.maxFreq)
    else $error("up/down frequency above maximum");
  both_hold_a: assert property (@(posedge clk) disable iff (srst)
    ud.up && ud.down && wasRun && ud.running && $past(ud.running) && live <= ud.maxFreq
    |=> live == $past(live) || !ud.running)
    else $error("frequency moved with both inputs");
endmodule : drc_updown

// >>> src/drive_run_command_logic.sv
// Summary of operation
// - Keypad inching needs the multi-key function set to inching key.
// - Keypad inching also needs run command source set to keypad.
// - Multi key press toggles the inching armed indicator.
// - Armed inching with forward or reverse key held runs at inching frequency.
// - Releasing both keys during inching stops the drive.
// - Inching uses its own acceleration and deceleration times.
// - Terminal function 17 is speed-up, 18 is speed-down.
// - Speed-up with run command raises speed; release holds speed.
// - Speed-down during run lowers speed; release holds speed.
// - Both speed-up and speed-down active: no speed change.
// - Save mode stores steady frequency when run drops, trip or power fails.
// - On run return the stored up/down frequency is used again.
// - Function 20 clears stored frequency while stopped or at steady speed.
// - Command source one plus function 14 latches momentary run inputs.
// - Forward and reverse together stop the drive.
// - Inching overrides up/down and three-wire speeds.
module drive_run_command_logic #(
  parameter int NUM_TERM = drc_pkg::NUM_TERM,
  parameter int STEP_CYCLES = drc_pkg::UD_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] multiKeyFunction,
  input wire logic [2:0] cmdSource,
  input wire logic udSaveMode,
  input wire logic [NUM_TERM*6-1:0] inputTerminalFunction,
  input wire logic [NUM_TERM-1:0] terminalLevel,
  input wire logic multiKey,
  input wire logic forwardKey,
  input wire logic reverseKey,
  input wire logic forwardRunInput,
  input wire logic reverseRunInput,
  input wire logic trip,
  input wire logic powerFail,
  input wire logic [drc_pkg::FREQ_W-1:0] inchingFrequency,
  input wire logic [drc_pkg::FREQ_W-1:0] maxFrequency,
  input wire logic [15:0] inchingAccelTime,
  input wire logic [15:0] inchingDecelTime,
  input wire logic [15:0] normalAccelTime,
  input wire logic [15:0] normalDecelTime,
  output drc_pkg::drc_dir_e direction,
  output logic [drc_pkg::FREQ_W-1:0] targetFrequency,
  output logic [15:0] accelTime,
  output logic [15:0] decelTime,
  output drc_pkg::drc_ramp_e rampSel,
  output logic inchingIndicator
);
  import drc_pkg::*;
  if (NUM_TERM < 1 || NUM_TERM > 16) begin : g_bad_term
    $error("NUM_TERM out of range");
  end
  if (STEP_CYCLES < 1) begin : g_bad_step
    $error("STEP_CYCLES must be positive");
  end
  // ==================================================
  // Terminal function decode
  function automatic logic termActive(input logic [NUM_TERM*6-1:0] funcs,
      input logic [NUM_TERM-1:0] lvl, input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (funcs[i*6 +: 6] == code && lvl[i]) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : termActive
  function automatic logic termAssigned(input logic [NUM_TERM*6-1:0] funcs,
      input logic [5:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      if (funcs[i*6 +: 6] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction : termAssigned
  logic speedUp;
  logic speedDown;
  logic udClear;
  logic threeWireStop;
  logic threeWireMode;
  logic inchAllowed;
  assign speedUp = termActive(inputTerminalFunction, terminalLevel, FUNC_SPEED_UP);
  assign speedDown = termActive(inputTerminalFunction, terminalLevel, FUNC_SPEED_DOWN);
  assign udClear = termActive(inputTerminalFunction, terminalLevel, FUNC_UD_CLEAR);
  assign threeWireStop = termActive(inputTerminalFunction, terminalLevel, FUNC_THREE_WIRE);
  assign threeWireMode = (cmdSource == CMD_SRC_TERM_ONE) &&
    termAssigned(inputTerminalFunction, FUNC_THREE_WIRE);
  assign inchAllowed = (multiKeyFunction == MULTI_KEY_INCHING) &&
    (cmdSource == CMD_SRC_KEYPAD);
  // ==================================================
  // Inching arm toggle
  logic multiKeyPrev;
  logic inchArmed;
  always_ff @(posedge clk) begin
    if (srst) begin
      multiKeyPrev <= 1'b0;
      inchArmed <= 1'b0;
    end else begin
      multiKeyPrev <= multiKey;
      if (!inchAllowed) begin
        inchArmed <= 1'b0;
      end else if (multiKey && !multiKeyPrev) begin
        inchArmed <= !inchArmed;
      end
    end
  end
  // ==================================================
  // Three-wire latch
  logic twFwd;
  logic twRev;
  always_ff @(posedge clk) begin
    if (srst) begin
      twFwd <= 1'b0;
      twRev <= 1'b0;
    end else if (!threeWireMode || !threeWireStop) begin
      twFwd <= 1'b0;
      twRev <= 1'b0;
    end else if (forwardRunInput && reverseRunInput) begin
      twFwd <= 1'b0;
      twRev <= 1'b0;
    end else if (forwardRunInput) begin
      twFwd <= 1'b1;
      twRev <= 1'b0;
    end else if (reverseRunInput) begin
      twFwd <= 1'b0;
      twRev <= 1'b1;
    end
  end
  // ==================================================
  // Run command resolution
  logic runFwd;
  logic runRev;
  logic running;
  logic inchFwd;
  logic inchRev;
  logic inching;
  always_comb begin
    if (threeWireMode) begin
      runFwd = twFwd;
      runRev = twRev;
    end else if (cmdSource == CMD_SRC_KEYPAD) begin
      runFwd = forwardKey;
      runRev = reverseKey;
    end else begin
      runFwd = forwardRunInput;
      runRev = reverseRunInput;
    end
  end
  assign running = (runFwd ^ runRev) && !trip && !powerFail;
  assign inchFwd = inchArmed && forwardKey && !reverseKey;
  assign inchRev = inchArmed && reverseKey && !forwardKey;
  assign inching = inchFwd || inchRev;
  // ==================================================
  // Up/down core
  drc_ud_if udBus ();
  assign udBus.up = speedUp;
  assign udBus.down = speedDown;
  assign udBus.running = running && !inchArmed;
  assign udBus.clear = udClear;
  assign udBus.save = (udSaveMode == UD_SAVE_ON);
  assign udBus.maxFreq = maxFrequency;
  drc_updown #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_updown (
    .clk(clk),
    .srst(srst),
    .ud(udBus)
  );
  // ==================================================
  // Output stage
  always_ff @(posedge clk) begin
    if (srst) begin
      direction <= DRC_DIR_STOP;
      targetFrequency <= FREQ_RESET;
      rampSel <= DRC_RAMP_NORMAL;
      accelTime <= 16'h0000;
      decelTime <= 16'h0000;
    end else if (inchArmed) begin
      rampSel <= DRC_RAMP_INCH;
      accelTime <= inchingAccelTime;
      decelTime <= inchingDecelTime;
      if (inching) begin
        direction <= inchFwd ? DRC_DIR_FWD : DRC_DIR_REV;
        targetFrequency <= inchingFrequency;
      end else begin
        direction <= DRC_DIR_STOP;
        targetFrequency <= FREQ_RESET;
      end
    end else begin
      rampSel <= DRC_RAMP_NORMAL;
      accelTime <= normalAccelTime;
      decelTime <= normalDecelTime;
      if (running) begin
        direction <= runFwd ? DRC_DIR_FWD : DRC_DIR_REV;
        targetFrequency <= udBus.freq;
      end else begin
        direction <= DRC_DIR_STOP;
        targetFrequency <= FREQ_RESET;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      inchingIndicator <= 1'b0;
    end else begin
      inchingIndicator <= inchArmed;
    end
  end
  // ==================================================
  // Checks
  inch_gate_a: assert property (@(posedge clk) disable iff (srst)
    multiKeyFunction != MULTI_KEY_INCHING |=> !inchArmed)
    else $error("inching armed without inching key setting");
  inch_src_a: assert property (@(posedge clk) disable iff (srst)
    cmdSource != CMD_SRC_KEYPAD |=> !inchArmed)
    else $error("inching armed without keypad source");
  toggle_a: assert property (@(posedge clk) disable iff (srst)
    inchAllowed && $rose(multiKey) && $past(inchAllowed) |=> inchArmed != $past(inchArmed))
    else $error("multi key did not toggle arming");
  inch_run_a: assert property (@(posedge clk) disable iff (srst)
    inchFwd |=> direction == DRC_DIR_FWD && targetFrequency == $past(inchingFrequency))
    else $error("inching forward not applied");
  inch_stop_a: assert property (@(posedge clk) disable iff (srst)
    inchArmed && !forwardKey && !reverseKey |=> direction == DRC_DIR_STOP)
    else $error("inching did not stop on key release");
  inch_ramp_a: assert property (@(posedge clk) disable iff (srst)
    inchArmed |=> accelTime == $past(inchingAccelTime) && rampSel == DRC_RAMP_INCH)
    else $error("inching ramp not selected");
  both_dir_a: assert property (@(posedge clk) disable iff (srst)
    !inchArmed && runFwd && runRev |=> direction == DRC_DIR_STOP)
    else $error("both directions did not stop");
  tw_clear_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && !threeWireStop |=> !twFwd && !twRev)
    else $error("three-wire latch not cleared by stop");
  tw_latch_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && threeWireStop && forwardRunInput && !reverseRunInput
    ##1 threeWireMode && threeWireStop && !forwardRunInput && !reverseRunInput |-> twFwd)
    else $error("three-wire forward not latched");
  ind_follow_a: assert property (@(posedge clk) disable iff (srst)
    1'b1 |=> inchingIndicator == $past(inchArmed))
    else $error("indicator does not follow arming");
  arm_hold_a: assert property (@(posedge clk) disable iff (srst)
    inchAllowed && !(multiKey && !multiKeyPrev) |=> inchArmed == $past(inchArmed))
    else $error("arming changed without multi key");
  inch_rev_a: assert property (@(posedge clk) disable iff (srst)
    inchRev |=> direction == DRC_DIR_REV && targetFrequency == $past(inchingFrequency))
    else $error("inching reverse not applied");
  inch_dec_a: assert property (@(posedge clk) disable iff (srst)
    inchArmed |=> decelTime == $past(inchingDecelTime))
    else $error("inching deceleration time not selected");
  norm_ramp_a: assert property (@(posedge clk) disable iff (srst)
    !inchArmed |=> rampSel == DRC_RAMP_NORMAL && accelTime == $past(normalAccelTime)
    && decelTime == $past(normalDecelTime))
    else $error("normal ramp not selected");
  inch_prio_a: assert property (@(posedge clk) disable iff (srst)
    inching && (speedUp || speedDown) |=> targetFrequency == $past(inchingFrequency))
    else $error("up/down overrode inching");
  ud_follow_a: assert property (@(posedge clk) disable iff (srst)
    !inchArmed && running |=> targetFrequency == $past(udBus.freq))
    else $error("target does not follow up/down frequency");
  run_stop_a: assert property (@(posedge clk) disable iff (srst)
    !inchArmed && !running |=> direction == DRC_DIR_STOP && targetFrequency == FREQ_RESET)
    else $error("drive not stopped without run command");
  fault_stop_a: assert property (@(posedge clk) disable iff (srst)
    !inchArmed && (trip || powerFail) |=> direction == DRC_DIR_STOP)
    else $error("drive not stopped on trip or power failure");
  ud_hold_a: assert property (@(posedge clk) disable iff (srst)
    udBus.running && $past(udBus.running) && !$past(srst) && !speedUp && !speedDown
    && udBus.freq <= maxFrequency |=> udBus.freq == $past(udBus.freq))
    else $error("up/down frequency moved with inputs released");
  ud_up_a: assert property (@(posedge clk) disable iff (srst)
    udBus.running && $past(udBus.running) && !$past(srst) && speedUp && !speedDown
    && udBus.freq <= maxFrequency |=> udBus.freq == $past(udBus.freq)
    || udBus.freq == $past(udBus.freq) + 16'h0001)
    else $error("speed-up moved frequency wrongly");
  ud_down_a: assert property (@(posedge clk) disable iff (srst)
    udBus.running && $past(udBus.running) && !$past(srst) && speedDown && !speedUp
    && udBus.freq <= maxFrequency |=> udBus.freq == $past(udBus.freq)
    || udBus.freq == $past(udBus.freq) - 16'h0001)
    else $error("speed-down moved frequency wrongly");
  ud_both_a: assert property (@(posedge clk) disable iff (srst)
    udBus.running && $past(udBus.running) && !$past(srst) && speedUp && speedDown
    && udBus.freq <= maxFrequency |=> udBus.freq == $past(udBus.freq))
    else $error("frequency moved with both inputs active");
  tw_rev_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && threeWireStop && reverseRunInput && !forwardRunInput
    ##1 threeWireMode && threeWireStop && !forwardRunInput && !reverseRunInput |-> twRev)
    else $error("three-wire reverse not latched");
  tw_both_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && threeWireStop && forwardRunInput && reverseRunInput |=> !twFwd && !twRev)
    else $error("three-wire latch kept with both inputs");
  tw_hold_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && threeWireStop && !forwardRunInput && !reverseRunInput
    |=> twFwd == $past(twFwd) && twRev == $past(twRev))
    else $error("three-wire latch changed without input");
  tw_off_a: assert property (@(posedge clk) disable iff (srst)
    !threeWireMode |=> !twFwd && !twRev)
    else $error("three-wire latch set outside three-wire mode");
  tw_dir_a: assert property (@(posedge clk) disable iff (srst)
    threeWireMode && twFwd && !twRev && !inchArmed && !trip && !powerFail
    |=> direction == DRC_DIR_FWD)
    else $error("latched forward run not applied");
endmodule : drive_run_command_logic

// >>> dv/drc_panel_model.sv
// ==================================================
// Keypad keys and run pushbuttons
module drc_panel_model #(
  parameter int HOLD_CYCLES = drc_pkg::MIN_INPUT_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] want,
  output logic [4:0] press
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold [5];
  logic [4:0] wantLast;
  // Every press stays active for the minimum recognised time
  always_ff @(posedge clk) begin
    wantLast <= want;
    for (int i = 0; i < 5; i++) begin
      if (srst) hold[i] <= 0;
      else if (want[i] && !wantLast[i]) hold[i] <= HOLD_CYCLES;
      else if (hold[i] != 0) hold[i] <= hold[i] - 1;
    end
  end
  // Released contacts fall back to inactive
  always_comb begin
    for (int i = 0; i < 5; i++) press[i] = want[i] || (hold[i] != 0);
  end
endmodule : drc_panel_model

// >>> dv/drive_run_command_logic_tb.sv
// ==================================================
// Bench for run command logic
module drive_run_command_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import drc_pkg::*;
  localparam int STEP = 4;
  localparam int HOLD = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] multiKeyFunction = 8'h00;
  logic [2:0] cmdSource = 3'h2;
  logic udSaveMode = 1'b0;
  logic [NUM_TERM*6-1:0] termFunc;
  logic [NUM_TERM-1:0] terminalLevel = 8'h00;
  logic [4:0] want = 5'h00;
  logic [4:0] press;
  logic trip = 1'b0;
  logic powerFail = 1'b0;
  logic [FREQ_W-1:0] inchFreq = 16'h0064;
  logic [FREQ_W-1:0] maxFreq = 16'h000C;
  logic [15:0] inAcc = 16'h8001;
  logic [15:0] inDec = 16'h8002;
  logic [15:0] nAcc = 16'h1111;
  logic [15:0] nDec = 16'h2222;
  drc_dir_e direction;
  drc_ramp_e rampSel;
  logic [FREQ_W-1:0] targetFrequency;
  logic [15:0] accelTime;
  logic [15:0] decelTime;
  logic inchingIndicator;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  int expFreq = 0;
  integer seed = 32'h54CFD1D7;
  assign termFunc = {24'h000000, FUNC_THREE_WIRE, FUNC_UD_CLEAR, FUNC_SPEED_DOWN, FUNC_SPEED_UP};
  always #12.5 clk = ~clk;
  drc_panel_model #(.HOLD_CYCLES(HOLD)) u_panel (.clk(clk), .srst(srst), .want(want),
    .press(press));
  drive_run_command_logic #(.NUM_TERM(NUM_TERM), .STEP_CYCLES(STEP)) u_dut (
    .clk(clk), .srst(srst), .multiKeyFunction(multiKeyFunction), .cmdSource(cmdSource),
    .udSaveMode(udSaveMode), .inputTerminalFunction(termFunc), .terminalLevel(terminalLevel),
    .multiKey(press[0]), .forwardKey(press[1]), .reverseKey(press[2]),
    .forwardRunInput(press[3]), .reverseRunInput(press[4]), .trip(trip),
    .powerFail(powerFail), .inchingFrequency(inchFreq), .maxFrequency(maxFreq),
    .inchingAccelTime(inAcc), .inchingDecelTime(inDec), .normalAccelTime(nAcc),
    .normalDecelTime(nDec), .direction(direction), .targetFrequency(targetFrequency),
    .accelTime(accelTime), .decelTime(decelTime), .rampSel(rampSel),
    .inchingIndicator(inchingIndicator));
  // ==================================================
  // Checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic dir(input drc_dir_e d);
    check({14'h0000, direction}, {14'h0000, d});
  endtask : dir
  // Up/down reference frequency within one step of the model
  task automatic near();
    int d;
    d = int'(targetFrequency) - expFreq;
    check({15'h0000, !$isunknown(targetFrequency) && d >= -1 && d <= 1}, 16'h0001);
  endtask : near
  task automatic press1(input logic [4:0] m);
    want <= m;
    cyc(1);
    want <= 5'h00;
    cyc(HOLD + 6);
  endtask : press1
  task automatic udStep(input logic [1:0] lv, input int n);
    terminalLevel[1:0] <= lv;
    cyc(n);
    terminalLevel[1:0] <= 2'b00;
    if (lv == 2'b01) expFreq = (expFreq + n / STEP > maxFreq) ? maxFreq : expFreq + n / STEP;
    if (lv == 2'b10) expFreq = (expFreq < n / STEP) ? 0 : expFreq - n / STEP;
    cyc(20);
    near();
  endtask : udStep
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==================================================
  // Scenarios
  initial begin
    cyc(20);
    srst <= 1'b0;
    inchFreq <= 16'h0010 + 16'($random(seed) & 32'h00FF);
    inAcc <= {1'b1, 15'($random(seed))};
    inDec <= {1'b1, 15'($random(seed))};
    cmdSource <= 3'h0;
    multiKeyFunction <= 8'h02;
    cyc(2);
    press1(5'h01);
    check({15'h0000, inchingIndicator}, 16'h0000);
    multiKeyFunction <= 8'h01;
    cmdSource <= 3'h1;
    press1(5'h01);
    check({15'h0000, inchingIndicator}, 16'h0000);
    cmdSource <= 3'h0;
    press1(5'h01);
    check({15'h0000, inchingIndicator}, 16'h0001);
    check({14'h0000, rampSel}, {14'h0000, DRC_RAMP_INCH});
    check(accelTime, inAcc);
    check(decelTime, inDec);
    want <= 5'h02;
    cyc(8);
    dir(DRC_DIR_FWD);
    check(targetFrequency, inchFreq);
    want <= 5'h06;
    cyc(8);
    dir(DRC_DIR_STOP);
    want <= 5'h00;
    cyc(HOLD + 6);
    dir(DRC_DIR_STOP);
    want <= 5'h04;
    cyc(8);
    dir(DRC_DIR_REV);
    want <= 5'h00;
    cyc(HOLD + 6);
    press1(5'h01);
    check(accelTime, nAcc);
    check(decelTime, nDec);
    check({14'h0000, rampSel}, {14'h0000, DRC_RAMP_NORMAL});
    want <= 5'h02;
    terminalLevel[0] <= 1'b1;
    cyc(20);
    want <= 5'h03;
    cyc(1);
    want <= 5'h02;
    cyc(HOLD + 6);
    check(targetFrequency, inchFreq);
    terminalLevel[0] <= 1'b0;
    press1(5'h01);
    cmdSource <= 3'h2;
    udSaveMode <= 1'b1;
    want <= 5'h08;
    cyc(8);
    udStep(2'b01, 100);
    udStep(2'b10, 100);
    udStep(2'b01, 20);
    udStep(2'b11, 40);
    want <= 5'h00;
    cyc(8);
    dir(DRC_DIR_STOP);
    want <= 5'h08;
    cyc(8);
    near();
    udStep(2'b01, 12);
    trip <= 1'b1;
    cyc(6);
    dir(DRC_DIR_STOP);
    trip <= 1'b0;
    cyc(6);
    near();
    udStep(2'b10, 8);
    powerFail <= 1'b1;
    cyc(6);
    dir(DRC_DIR_STOP);
    powerFail <= 1'b0;
    cyc(6);
    near();
    want <= 5'h00;
    cyc(6);
    terminalLevel[2] <= 1'b1;
    cyc(6);
    terminalLevel[2] <= 1'b0;
    want <= 5'h08;
    cyc(8);
    expFreq = 0;
    near();
    udSaveMode <= 1'b0;
    udStep(2'b01, 20);
    want <= 5'h00;
    cyc(6);
    want <= 5'h08;
    cyc(8);
    expFreq = 0;
    near();
    want <= 5'h00;
    cmdSource <= 3'h1;
    terminalLevel[3] <= 1'b1;
    cyc(4);
    press1(5'h08);
    dir(DRC_DIR_FWD);
    terminalLevel[3] <= 1'b0;
    cyc(6);
    dir(DRC_DIR_STOP);
    terminalLevel[3] <= 1'b1;
    cyc(4);
    press1(5'h10);
    dir(DRC_DIR_REV);
    want <= 5'h18;
    cyc(10);
    dir(DRC_DIR_STOP);
    want <= 5'h00;
    cyc(4);
    stop_test();
  end
endmodule : drive_run_command_logic_tb
